// ===== core/ocr_delay.sv
`timescale 1ns/1ps
`default_nettype none
// counts delay units of programmable length; restarts on start, abandoned on abort
module ocr_delay
    import ocr_pkg::*;
#(
    parameter int UNIT_CYCLES = OCR_UNIT_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,    // restart the count from zero
    input  wire logic       abort,    // drop the count with no expiry
    input  wire logic [2:0] units,    // number of delay units
    output var  logic       expired   // one-cycle pulse at the end
);
    // elaboration check: a unit of zero cycles cannot be counted
    if (UNIT_CYCLES < 1) begin : g_bad_unit
        $error("unit must be at least one cycle");
    end
    // ==========================================================
    // counter; 64-bit so that full units never wrap
    logic        active;
    logic [63:0] count;
    logic        next_active;
    logic [63:0] next_count;
    logic        next_expired;
    logic [63:0] target;

    always_comb begin
        target       = 64'(units) * 64'(UNIT_CYCLES);
        next_active  = active;
        next_count   = count;
        next_expired = 1'b0;
        if (start) begin
            next_active = 1'b1;
            next_count  = 64'h0;
        end else if (abort) begin
            next_active = 1'b0;
        end else if (active) begin
            if (count >= target) begin
                next_active  = 1'b0;
                next_expired = 1'b1;
            end else begin
                next_count = count + 64'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active  <= 1'b0;
            count   <= 64'h0;
            expired <= 1'b0;
        end else begin
            active  <= next_active;
            count   <= next_count;
            expired <= next_expired;
        end
    end
endmodule
`default_nettype wire

// ===== core/ocr_fault_response.sv
`timescale 1ns/1ps
`default_nettype none
module ocr_fault_response
    import ocr_pkg::*;
#(
    parameter int          PAGES       = 2,               // channels behind the page register
    parameter int          UNIT_CYCLES = OCR_UNIT_CYCLES, // cycles per 16 ms unit
    parameter logic [31:0] INTERVAL_CYCLES_W = 32'd1      // width guard for interval
) (
    input  wire logic        clk,
    input  wire logic        rst,
    // command access, one byte per transfer
    input  wire logic        cmd_write,          // write strobe, one cycle
    input  wire logic [7:0]  cmd_code,           // command code
    input  wire logic [7:0]  cmd_wdata,          // the one data byte
    input  wire logic        page,               // selected channel
    output logic [7:0]       cmd_rdata,          // read data of addressed command
    output logic             cmd_hit,            // code addressed this block
    // nonvolatile restore
    input  wire logic        nvm_load,           // restore pulse
    input  wire logic [7:0]  nvm_value,          // restored byte for the page
    // fault and channel control
    input  wire logic        oc_fault,           // threshold comparator, async
    input  wire logic        channel_run_pin,    // run pin, async
    input  wire logic        operation_on,       // operation command on, same clock
    input  wire logic        clear_faults,       // clear faults pulse
    input  wire logic        alert_mask,         // masks the alert
    input  wire logic        other_fault_off,    // another fault forced shutdown
    input  wire logic        restart_tick,       // restart_interval_setting expiry pulse
    output logic             output_enable,      // channel output allowed
    output logic             current_limit,      // hold current at the limit
    output logic             restart_timer_go,   // start the restart interval
    output ocr_status_t      status,             // status flags
    output logic             alert               // alert toward host
);
    // elaboration checks: the page select is one bit wide and the interval width is not zero
    if (PAGES != 2) begin : g_bad_pages
        $error("page select is one bit, PAGES must be 2");
    end
    if (INTERVAL_CYCLES_W == 32'd0) begin : g_bad_interval
        $error("bad interval width");
    end
    // ==========================================================
    // synchronised pins
    logic fault_s;   // fault after synchroniser
    logic run_s;     // run pin after synchroniser

    ocr_sync #(.RESET_VALUE(1'b0)) u_sync_fault (
        .clk      (clk),
        .rst      (rst),
        .async_in (oc_fault),
        .sync_out (fault_s)
    );
    ocr_sync #(.RESET_VALUE(1'b0)) u_sync_run (
        .clk      (clk),
        .rst      (rst),
        .async_in (channel_run_pin),
        .sync_out (run_s)
    );

    // ==========================================================
    // response byte storage, one per page
    logic [7:0] resp      [PAGES];
    logic [7:0] next_resp [PAGES];
    logic [7:0] next_rdata;
    logic       next_hit;

    always_comb begin
        for (int i = 0; i < PAGES; i++) next_resp[i] = resp[i];
        if (nvm_load) begin
            next_resp[page] = nvm_value;
        end else if (cmd_write && cmd_code == OCR_CMD_RESPONSE) begin
            next_resp[page] = cmd_wdata;
        end
        next_hit   = (cmd_code == OCR_CMD_RESPONSE);
        next_rdata = next_hit ? resp[page] : 8'h00;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < PAGES; i++) resp[i] <= OCR_RESPONSE_RESET;
            cmd_rdata <= 8'h00;
            cmd_hit   <= 1'b0;
        end else begin
            for (int i = 0; i < PAGES; i++) resp[i] <= next_resp[i];
            cmd_rdata <= next_rdata;
            cmd_hit   <= next_hit;
        end
    end

    // ==========================================================
    // the channel runs on page 0's byte; page 1 serves a sibling instance
    logic [1:0] mode;
    logic [2:0] retry;
    logic [2:0] units;
    assign mode  = resp[0][OCR_MODE_MSB:OCR_MODE_LSB];
    assign retry = resp[0][OCR_RETRY_MSB:OCR_RETRY_LSB];
    assign units = resp[0][OCR_DELAY_MSB:OCR_DELAY_LSB];

    // ==========================================================
    // on-request detection: a low-to-high of the combined command
    logic on_cmd;
    logic on_prev;
    logic fault_prev;
    logic fault_rise;
    logic turn_on;
    assign on_cmd     = run_s & operation_on;
    assign fault_rise = fault_s & ~fault_prev;
    assign turn_on    = on_cmd & ~on_prev;

    // ==========================================================
    // channel state, declared here because the delay arming reads it
    ocr_state_t  state;
    ocr_state_t  next_state;
    logic        run_prev;   // state was RUN last cycle
    // ==========================================================
    // deglitch delay, only armed in mode 10
    // a fault standing on entry into RUN arms it too, so a restart into a fault still times out
    logic dly_start;
    logic dly_abort;
    logic dly_done;
    assign dly_start = fault_s && (fault_rise || !run_prev)
                     && mode == OCR_MODE_DEGLITCH && state == OCR_RUN;
    assign dly_abort = ~fault_s | state != OCR_RUN;

    ocr_delay #(.UNIT_CYCLES(UNIT_CYCLES)) u_delay (
        .clk     (clk),
        .rst     (rst),
        .start   (dly_start),
        .abort   (dly_abort),
        .units   (units),
        .expired (dly_done)
    );

    // ==========================================================
    // channel state machine
    logic        next_oe;
    logic        next_limit;
    logic        next_go;
    logic        shut;

    always_comb begin
        next_state = state;
        next_go    = 1'b0;
        shut       = 1'b0;
        case (state)
            OCR_RUN: begin
                if (mode == OCR_MODE_SHUTDOWN && fault_s) begin
                    shut = 1'b1;
                end else if (mode == OCR_MODE_DEGLITCH && dly_done && fault_s) begin
                    shut = 1'b1;
                end
                // modes 00 and 01 never shut down here
                if (shut) begin
                    if (retry == OCR_RETRY_FOREVER) begin
                        next_state = OCR_RETRY;
                        next_go    = 1'b1;
                    end else begin
                        next_state = OCR_OFF;
                    end
                end
                if (!on_cmd || other_fault_off) next_state = OCR_OFF;
            end
            OCR_OFF: begin
                // only a fresh turn-on releases the latch
                if (turn_on && !other_fault_off) next_state = OCR_RUN;
            end
            OCR_RETRY: begin
                if (!on_cmd || other_fault_off) begin
                    next_state = OCR_OFF;
                end else if (restart_tick) begin
                    next_state = OCR_RUN;
                end
            end
            default: next_state = OCR_OFF;
        endcase
        next_oe    = (next_state == OCR_RUN);
        // brick-wall limiting while faulted and running in modes 00, 01 and 10
        next_limit = next_oe & fault_s & (mode != OCR_MODE_SHUTDOWN);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state            <= OCR_OFF;
            run_prev         <= 1'b0;
            on_prev          <= 1'b0;
            fault_prev       <= 1'b0;
            output_enable    <= 1'b0;
            current_limit    <= 1'b0;
            restart_timer_go <= 1'b0;
        end else begin
            state            <= next_state;
            run_prev         <= (state == OCR_RUN);
            on_prev          <= on_cmd;
            fault_prev       <= fault_s;
            output_enable    <= next_oe;
            current_limit    <= next_limit;
            restart_timer_go <= next_go;
        end
    end

    // ==========================================================
    // sticky status and alert; a fault in the clear cycle wins
    ocr_status_t next_status;
    logic        next_alert;
    logic        flag_clear;
    assign flag_clear = clear_faults | turn_on;

    always_comb begin
        next_status = status;
        if (flag_clear) next_status = '0;
        if (fault_s) next_status = '1;
        next_alert = next_status.status_iout_oc & ~alert_mask;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status <= '0;
            alert  <= 1'b0;
        end else begin
            status <= next_status;
            alert  <= next_alert;
        end
    end

    // ==========================================================
    // checks
    sequence s_fault_seen;
        fault_s;
    endsequence
    sequence s_flags_up;
        ##1 status == 3'b111;
    endsequence

    a_flag_set_now: assert property (@(posedge clk) disable iff (rst)
        s_fault_seen |-> s_flags_up) else $error("fault did not set flags");
    a_alert_follow: assert property (@(posedge clk) disable iff (rst)
        (status.status_iout_oc && !alert_mask && !flag_clear) |=> alert) else $error("alert missing");
    a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
        (status.status_iout_oc && !flag_clear) |=> status.status_iout_oc) else $error("flag dropped");
    a_limit_no_off: assert property (@(posedge clk) disable iff (rst)
        (state == OCR_RUN && mode == OCR_MODE_LIMIT && on_cmd && !other_fault_off)
        |=> state == OCR_RUN) else $error("mode 00 shut down");
    a_shut_at_once: assert property (@(posedge clk) disable iff (rst)
        (state == OCR_RUN && mode == OCR_MODE_SHUTDOWN && fault_s)
        |=> state != OCR_RUN) else $error("mode 11 did not shut");
    a_latch_off: assert property (@(posedge clk) disable iff (rst)
        (state == OCR_OFF && !turn_on) |=> state == OCR_OFF) else $error("left off without run cycle");
    a_retry_go: assert property (@(posedge clk) disable iff (rst)
        (state == OCR_RUN && shut && retry == OCR_RETRY_FOREVER && on_cmd && !other_fault_off)
        |=> restart_timer_go && state == OCR_RETRY) else $error("retry not started");
    a_retry_wait: assert property (@(posedge clk) disable iff (rst)
        (state == OCR_RETRY && !restart_tick) |=> state != OCR_RUN) else $error("restart without interval");
    a_delay_only: assert property (@(posedge clk) disable iff (rst)
        (state == OCR_RUN && mode == OCR_MODE_DEGLITCH && !dly_done && on_cmd && !other_fault_off)
        |=> state == OCR_RUN) else $error("deglitch shut early");
    a_delay_abort: assert property (@(posedge clk) disable iff (rst)
        (!fault_s) |=> !dly_done) else $error("delay expired after recovery");

    // ==========================================================
    // further checks on decode, limiting, retry and clearing
    // register decode and storage
    a_read_hit: assert property (@(posedge clk) disable iff (rst)
        (cmd_code == OCR_CMD_RESPONSE) |=> cmd_hit) else $error("response code not answered");
    a_read_miss: assert property (@(posedge clk) disable iff (rst)
        (cmd_code != OCR_CMD_RESPONSE)
        |=> (!cmd_hit && cmd_rdata == 8'h00)) else $error("foreign code answered");
    a_write_store: assert property (@(posedge clk) disable iff (rst)
        (cmd_write && cmd_code == OCR_CMD_RESPONSE && !nvm_load && page == 1'b0)
        |=> resp[0] == $past(cmd_wdata)) else $error("write not stored");
    // status clearing and alert masking
    a_status_clear: assert property (@(posedge clk) disable iff (rst)
        (flag_clear && !fault_s) |=> status == 3'b000) else $error("flags not cleared");
    a_alert_masked: assert property (@(posedge clk) disable iff (rst)
        alert_mask |=> !alert) else $error("masked alert raised");
    // limiting level follows the synchronised fault while running in modes 00, 01 and 10
    a_limit_level: assert property (@(posedge clk) disable iff (rst)
        (state == OCR_RUN && fault_s && mode != OCR_MODE_SHUTDOWN && !shut && on_cmd && !other_fault_off)
        |=> current_limit) else $error("not limiting in fault");
    a_limit_off: assert property (@(posedge clk) disable iff (rst)
        (!fault_s) |=> !current_limit) else $error("limiting without fault");
    // deglitch expiry and retry policy
    a_deglitch_shut: assert property (@(posedge clk) disable iff (rst)
        (state == OCR_RUN && mode == OCR_MODE_DEGLITCH && dly_done && fault_s)
        |=> state != OCR_RUN) else $error("deglitch expiry ignored");
    a_retry_latch: assert property (@(posedge clk) disable iff (rst)
        (state == OCR_RUN && shut && retry != OCR_RETRY_FOREVER)
        |=> (state == OCR_OFF && !restart_timer_go)) else $error("latching retry restarted");
    a_go_pulse: assert property (@(posedge clk) disable iff (rst)
        restart_timer_go |=> !restart_timer_go) else $error("restart request held");
endmodule
`default_nettype wire

// ===== core/ocr_pkg.sv
package ocr_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] OCR_CMD_RESPONSE   = 8'h47;  // overcurrent response command code
    localparam logic [7:0] OCR_RESPONSE_RESET = 8'h00;  // value after reset
    // ==========================================================
    // field positions inside the response byte
    localparam int OCR_MODE_MSB  = 7;
    localparam int OCR_MODE_LSB  = 6;
    localparam int OCR_RETRY_MSB = 5;
    localparam int OCR_RETRY_LSB = 3;
    localparam int OCR_DELAY_MSB = 2;
    localparam int OCR_DELAY_LSB = 0;
    // ==========================================================
    // encodings
    localparam logic [1:0] OCR_MODE_LIMIT    = 2'h0;  // limit forever
    localparam logic [1:0] OCR_MODE_RSVD     = 2'h1;  // unsupported, treated as limit
    localparam logic [1:0] OCR_MODE_DEGLITCH = 2'h2;  // limit then shut down after delay
    localparam logic [1:0] OCR_MODE_SHUTDOWN = 2'h3;  // shut down at once
    localparam logic [2:0] OCR_RETRY_FOREVER = 3'h7;  // only this value restarts
    // ==========================================================
    // timing
    localparam int OCR_CLK_MHZ    = 200;                    // clock rate
    localparam int OCR_UNIT_MS    = 16;                     // delay unit in ms
    localparam int OCR_UNIT_CYCLES = OCR_UNIT_MS * 1000 * OCR_CLK_MHZ; // ms to us, times cycles per us: 3.2e6
    // ==========================================================
    // types
    typedef enum logic [1:0] {
        OCR_RUN,      // output on, normal or limiting
        OCR_OFF,      // latched off, waits for run cycle
        OCR_RETRY     // off, waiting for restart interval
    } ocr_state_t;

    typedef struct packed {
        logic status_byte_iout_oc;  // summary flag in the status byte
        logic status_word_iout;     // summary flag in the status word
        logic status_iout_oc;       // overcurrent flag in the iout status
    } ocr_status_t;
endpackage

// ===== core/ocr_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; a change counts when stages two and three agree
module ocr_sync
    import ocr_pkg::*;
#(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic async_in,
    output var  logic sync_out
);
    // ==========================================================
    // synchroniser chain
    logic [2:0] stage;       // stage[0] only feeds stage[1]
    logic [2:0] next_stage;
    logic       next_out;

    always_comb begin
        next_stage = {stage[1:0], async_in};
        // hold the old level while the two later stages disagree
        next_out   = (stage[1] == stage[2]) ? stage[2] : sync_out;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage    <= {3{RESET_VALUE}};
            sync_out <= RESET_VALUE;
        end else begin
            stage    <= next_stage;
            sync_out <= next_out;
        end
    end
endmodule
`default_nettype wire

// ===== tb/ocr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bus host stand-in: one data byte per command transfer
module ocr_host (
    input  wire logic       clk,
    output var  logic       cmd_write,  // write strobe
    output var  logic [7:0] cmd_code,   // command code
    output var  logic [7:0] cmd_wdata,  // the data byte
    output var  logic       page,       // channel select
    input  wire logic [7:0] cmd_rdata,  // read answer
    input  wire logic       cmd_hit     // code matched
);
    // idle bus before the first transfer
    initial begin
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 8'h00;
        page      = 1'b0;
    end
    // write one byte; idle values are inverted so stale data never looks valid
    task automatic write_byte(input logic p, input logic [7:0] code, input logic [7:0] d);
        @(posedge clk);
        cmd_write <= 1'b1;
        cmd_code  <= code;
        cmd_wdata <= d;
        page      <= p;
        @(posedge clk);
        cmd_write <= 1'b0;
        cmd_code  <= ~code;
        cmd_wdata <= ~d;
    endtask
    // read one byte; code held until the registered answer is taken
    task automatic read_byte(input logic p, input logic [7:0] code, output logic [7:0] d, output logic h);
        @(posedge clk);
        cmd_code <= code;
        page     <= p;
        @(posedge clk);
        @(posedge clk);
        d = cmd_rdata;
        h = cmd_hit;
        cmd_code <= ~code;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench for the overcurrent response block
module tb_top
    import ocr_pkg::*;
();
    localparam int UNIT = 10;  // shortened 16 ms unit keeps the run brief
    logic        clk, rst, cmd_write, page, cmd_hit, nvm_load, oc_fault, run_pin;
    logic        operation_on, clear_faults, alert_mask, restart_tick, go_seen, other_off;
    logic        output_enable, current_limit, restart_timer_go, alert;
    logic [7:0]  cmd_code, cmd_wdata, cmd_rdata, nvm_value;
    ocr_status_t status;      // sticky flags
    int          errors, n_compared, seed;

    // ==========================================================
    // design and host
    ocr_fault_response #(.UNIT_CYCLES(UNIT)) ocr_fault_response_inst (
        .clk(clk), .rst(rst), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .page(page), .cmd_rdata(cmd_rdata), .cmd_hit(cmd_hit),
        .nvm_load(nvm_load), .nvm_value(nvm_value), .oc_fault(oc_fault),
        .channel_run_pin(run_pin), .operation_on(operation_on), .clear_faults(clear_faults),
        .alert_mask(alert_mask), .other_fault_off(other_off), .restart_tick(restart_tick),
        .output_enable(output_enable), .current_limit(current_limit),
        .restart_timer_go(restart_timer_go), .status(status), .alert(alert));
    ocr_host ocr_host_inst (
        .clk(clk), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .page(page), .cmd_rdata(cmd_rdata), .cmd_hit(cmd_hit));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ==========================================================
    // helpers
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // counts cycles while noting any restart request
    task automatic watch(input int n);
        repeat (n) begin
            @(posedge clk);
            go_seen |= restart_timer_go;
        end
    endtask
    // bounded wait for the output to reach a level
    task automatic wait_oe(input logic v, input int n);
        for (int k = 0; k < n && output_enable !== v; k++) @(posedge clk);
    endtask
    // turn the channel off and on through the operation level
    task automatic power_cycle();
        operation_on <= 1'b0;
        cyc(8);
        operation_on <= 1'b1;
        wait_oe(1'b1, 20);
        cyc(2);
    endtask
    // time spent limiting before a deglitched shutdown; zero for other modes
    function automatic int limit_cycles(input logic [7:0] b);
        return (b[OCR_MODE_MSB:OCR_MODE_LSB] == OCR_MODE_DEGLITCH) ? int'(b[2:0]) * UNIT : 0;
    endfunction
    task automatic conclude();
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs under a thousand cycles
    initial begin
        #(5 * 20000);
        errors++;
        conclude();
    end

    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] b, d;
        logic       h;
        seed = 56036;
        errors = 0;
        n_compared = 0;
        {rst, run_pin} = 2'h3;
        {nvm_load, nvm_value, oc_fault, operation_on, clear_faults, alert_mask, restart_tick, other_off} = 15'h0;
        cyc(2);
        rst <= 1'b0;
        // defaults, unmapped code, random bytes on both pages
        ocr_host_inst.read_byte(1'b0, OCR_CMD_RESPONSE, d, h);
        chk(d === OCR_RESPONSE_RESET && h === 1'b1, "reset value");
        ocr_host_inst.read_byte(1'b1, 8'h46, d, h);
        chk(d === 8'h00 && h === 1'b0, "unmapped code answered");
        for (int n = 0; n < 6; n++) begin
            b = 8'($random(seed));
            ocr_host_inst.write_byte(n[0], OCR_CMD_RESPONSE, b);
            ocr_host_inst.write_byte(n[0], 8'h46, ~b);
            ocr_host_inst.read_byte(n[0], OCR_CMD_RESPONSE, d, h);
            chk(d === b, "readback");
        end
        // restore of the saved copy into page 1
        nvm_value <= 8'h5A;
        nvm_load <= 1'b1;
        cyc(1);
        nvm_load <= 1'b0;
        ocr_host_inst.read_byte(1'b1, OCR_CMD_RESPONSE, d, h);
        chk(d === 8'h5A, "restored value");
        power_cycle();
        // limit modes, the unsupported code among them, masked alert last
        for (int m = 0; m < 3; m++) begin
            b = {(m == 1) ? OCR_MODE_RSVD : OCR_MODE_LIMIT, 6'($random(seed))};
            alert_mask <= (m == 2);
            ocr_host_inst.write_byte(1'b0, OCR_CMD_RESPONSE, b);
            oc_fault <= 1'b1;
            cyc(90);
            chk(output_enable === 1'b1 && current_limit === 1'b1, "limit mode shut down");
            chk(status === 3'h7, "status flags");
            chk(alert === (m != 2), "alert level");
            oc_fault <= 1'b0;
            cyc(10);
            chk(status === 3'h7 && current_limit === 1'b0, "flags not sticky");
            clear_faults <= 1'b1;
            cyc(1);
            clear_faults <= 1'b0;
            cyc(3);
            chk(status === 3'h0 && alert === 1'b0, "clear faults");
        end
        alert_mask <= 1'b0;
        // deglitched shutdown; a brief overload must be forgotten
        b = {OCR_MODE_DEGLITCH, 3'h0, 3'(1 + ($random(seed) & 32'h5))};
        ocr_host_inst.write_byte(1'b0, OCR_CMD_RESPONSE, b);
        oc_fault <= 1'b1;
        cyc(5);
        oc_fault <= 1'b0;
        cyc(limit_cycles(b) + 20);
        chk(output_enable === 1'b1, "short overload shut down");
        oc_fault <= 1'b1;
        cyc(limit_cycles(b));
        chk(output_enable === 1'b1 && current_limit === 1'b1, "deglitch ended early");
        wait_oe(1'b0, 12);
        chk(output_enable === 1'b0, "deglitch never shut down");
        oc_fault <= 1'b0;
        cyc(30);
        chk(output_enable === 1'b0, "restarted without retry");
        // run pin cycle brings the channel back and clears the flags
        run_pin <= 1'b0;
        cyc(8);
        run_pin <= 1'b1;
        wait_oe(1'b1, 20);
        cyc(2);
        chk(output_enable === 1'b1 && status === 3'h0, "run pin cycle");
        // immediate shutdown with a latching and a restarting retry field
        for (int r = 0; r < 2; r++) begin
            b = {OCR_MODE_SHUTDOWN, (r == 1) ? OCR_RETRY_FOREVER : 3'($unsigned($random(seed)) % 7),
                 3'($random(seed))};
            ocr_host_inst.write_byte(1'b0, OCR_CMD_RESPONSE, b);
            go_seen = 1'b0;
            oc_fault <= 1'b1;
            watch(7);
            chk(output_enable === 1'b0, "no immediate shutdown");
            oc_fault <= 1'b0;
            watch(30);
            chk(go_seen === (r == 1) && output_enable === 1'b0, "restart interval");
            restart_tick <= 1'b1;
            cyc(1);
            restart_tick <= 1'b0;
            cyc(3);
            chk(output_enable === (r == 1), "retry policy");
            power_cycle();
        end
        // another fault ends the endless retry; only a fresh turn-on brings it back
        b = {OCR_MODE_SHUTDOWN, OCR_RETRY_FOREVER, 3'h0};
        ocr_host_inst.write_byte(1'b0, OCR_CMD_RESPONSE, b);
        oc_fault <= 1'b1;
        cyc(7);
        oc_fault <= 1'b0;
        other_off <= 1'b1;
        cyc(2);
        other_off <= 1'b0;
        restart_tick <= 1'b1;
        cyc(1);
        restart_tick <= 1'b0;
        cyc(3);
        chk(output_enable === 1'b0, "other fault did not end retry");
        power_cycle();
        chk(output_enable === 1'b1 && status === 3'h0, "operation cycle");
        conclude();
    end
endmodule
`default_nettype wire
